// ===== hw/cor_pkg.sv
`default_nettype none
package cor_pkg;

  // bus command codes of the two option registers
  localparam logic [7:0]  CMD_OPT2      = 8'h31;
  localparam logic [7:0]  CMD_OPT3      = 8'h32;
  localparam logic [15:0] OPT2_RESET    = 16'h02B7;
  localparam logic [15:0] OPT3_RESET    = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // field positions used by write side effects
  localparam int OPT2_OVLD_FLAG_BIT  = 11;
  localparam int OPT2_RELAX_FLAG_BIT = 10;
  localparam int OPT3_REG_RESET_BIT  = 14;
  localparam int OPT3_REMEASURE_BIT  = 13;

  // peak power interval tables in ms, indexed by field code
  localparam logic [5:0] OVLD_MS_0   = 6'h01;
  localparam logic [5:0] OVLD_MS_1   = 6'h02;
  localparam logic [5:0] OVLD_MS_2   = 6'h0A;
  localparam logic [5:0] OVLD_MS_3   = 6'h14;
  localparam logic [5:0] PERIOD_MS_0 = 6'h05;
  localparam logic [5:0] PERIOD_MS_1 = 6'h0A;
  localparam logic [5:0] PERIOD_MS_2 = 6'h14;
  localparam logic [5:0] PERIOD_MS_3 = 6'h28;

  // timing
  localparam int CLK_MHZ      = 125;
  localparam int MS_US        = 1000;
  localparam int BLANK_US     = 100;
  localparam int MS_CYCLES    = MS_US * CLK_MHZ;
  localparam int BLANK_CYCLES = BLANK_US * CLK_MHZ;

  // bus address; arbitrary value
  localparam logic [6:0] SLAVE_ADDR = 7'h09;

  typedef struct packed {
    logic [1:0] peak_overload_duration;
    logic       peak_trigger_on_input_overshoot;
    logic       peak_trigger_on_sys_undershoot;
    logic       overload_cycle_flag;
    logic       relax_cycle_flag;
    logic [1:0] overload_relax_period;
    logic       external_limit_select;
    logic       current_monitor_direction;
    logic       low_side_switch_trip_level;
    logic       input_sense_trip_level;
    logic       input_overcurrent_enable;
    logic       input_overcurrent_ratio;
    logic       discharge_overcurrent_enable;
    logic       discharge_overcurrent_ratio;
  } cor_opt2_s;

  typedef struct packed {
    logic       high_impedance_enable;
    logic       register_reset;
    logic       input_voltage_threshold_remeasure;
    logic       reverse_power_out_enable;
    logic       input_optimization_enable;
    logic [2:0] reserved_hi;
    logic [5:0] reserved_lo;
    logic       battery_switch_off_in_high_z;
    logic       system_power_monitor_select;
  } cor_opt3_s;

  typedef enum logic [1:0] {
    PK_IDLE  = 2'b00,
    PK_OVLD  = 2'b01,
    PK_RELAX = 2'b10
  } cor_pk_e;

  typedef enum logic [3:0] {
    SMB_IDLE  = 4'b0000,
    SMB_ADDR  = 4'b0001,
    SMB_AACK  = 4'b0010,
    SMB_CMD   = 4'b0011,
    SMB_CACK  = 4'b0100,
    SMB_WDATA = 4'b0101,
    SMB_WACK  = 4'b0110,
    SMB_RDATA = 4'b0111,
    SMB_RACK  = 4'b1000
  } cor_smb_e;

endpackage
`default_nettype wire

// ===== hw/cor_regs.sv
// What this block does
// RULE1 - bits 15-14 pick overload time 1, 2, 10 or 20 ms; reset 00b
// RULE2 - bit 13 lets input current overshoot start peak power; reset 0
// RULE3 - bit 12 lets system voltage undershoot start peak power; reset 0
// RULE4 - both trigger enables clear keeps peak power mode off
// RULE5 - adapter removal clears both trigger enables by hardware
// RULE6 - bit 11 shows overload cycle; host writing 0 ends it
// RULE7 - bit 10 shows relax cycle; host writing 0 ends it
// RULE8 - bits 9-8 pick cycle period 5, 10, 20 or 40 ms; reset 10b
// RULE9 - overload longer than period means no relax interval
// RULE10 - bit 7 picks register limit or lower of pin and register
// RULE11 - bit 6 picks discharge or charge current on monitor output
// RULE12 - bit 5 sets low-side switch trip 210 mV or 150 mV
// RULE13 - bit 4 sets input sense trip 280 mV or 150 mV
// RULE14 - enabled input overcurrent lasting past 100 us disables converter
// RULE15 - bit 2 sets input trip at 125% or 200% of critical current
// RULE16 - enabled discharge overcurrent disables converter
// RULE17 - bit 0 sets discharge trip at 125% or 200% of throttle limit
// RULE18 - first option register at command 31h, 16-bit read/write
// RULE19 - second option register at command 32h, resets to zero
// RULE20 - register reset bit restores defaults then reads back zero
// RULE21 - remeasure bit disables converter until measurement done, then clears
// RULE22 - peak power alternates overload and relax, flags follow each phase
// RULE23 - all fields take defaults at power-on reset
`timescale 1ns/10ps
`default_nettype none
module cor_regs #(
  parameter int TICK_CYCLES  = cor_pkg::MS_CYCLES,
  parameter int BLANK_CYCLES = cor_pkg::BLANK_CYCLES
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // bus pins, open drain
  input  wire logic              smb_scl_in,
  input  wire logic              smb_sda_in,
  output logic                   smb_sda_out,
  output logic                   smb_sda_oe,
  // analog condition pins
  input  wire logic              adapter_present,
  input  wire logic              input_overshoot,
  input  wire logic              sys_undershoot,
  input  wire logic              input_overcurrent,
  input  wire logic              discharge_overcurrent,
  // on-chip logic, same clock
  input  wire logic              measure_done,
  input  wire logic [7:0]        reg_current_limit,
  input  wire logic [7:0]        external_limit_pin,
  input  wire logic [7:0]        charge_current,
  input  wire logic [7:0]        discharge_current,
  // configuration and status
  output cor_pkg::cor_opt2_s     charge_option_two,
  output cor_pkg::cor_opt3_s     charge_option_three,
  output logic                   converter_disable,
  output logic [7:0]             input_current_limit,
  output logic [7:0]             battery_current_monitor_pin,
  output logic                   registers_restore
);
  logic [6:0]        pins_s;
  logic              scl_s, sda_s, scl_q, sda_q;
  logic              adapter_s, overshoot_s, undershoot_s, acoc_s, batoc_s, adapter_q;
  cor_pkg::cor_smb_e smb_state;
  logic [2:0]        bit_cnt;
  logic              byte_full, rw, byte_hi, rack_nack;
  logic [7:0]        shreg, cmd, wlo, txb;
  logic [15:0]       rd_val;
  logic              wr_stb;
  logic [7:0]        wr_cmd;
  logic [15:0]       wr_data;
  cor_pkg::cor_pk_e  pk_state, next_pk;
  logic [16:0]       tick_cnt;
  logic [5:0]        ms_cnt, ovld_ms, period_ms, relax_ms;
  logic [13:0]       blank_cnt;
  logic              acoc_trip, batoc_trip;
  logic              scl_rise, scl_fall, start_c, stop_c, tick;
  logic              wr2, wr3, restore, trig, clr_ovld, clr_relax;

  // pins cross in through two flops before use
  cor_sync #(.W(7), .INIT(7'h60)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({smb_scl_in, smb_sda_in, adapter_present, input_overshoot,
             sys_undershoot, input_overcurrent, discharge_overcurrent}),
    .q     (pins_s)
  );
  assign {scl_s, sda_s, adapter_s, overshoot_s, undershoot_s, acoc_s, batoc_s} = pins_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      adapter_q <= 1'b0;
    end else begin
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      adapter_q <= adapter_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  always_comb begin
    case (cmd)
      cor_pkg::CMD_OPT2: rd_val = charge_option_two; // RULE18
      cor_pkg::CMD_OPT3: rd_val = charge_option_three;
      default:           rd_val = cor_pkg::UNMAPPED_READ;
    endcase
  end

  // bus slave: word write and word read, low byte first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      smb_state   <= cor_pkg::SMB_IDLE;
      bit_cnt     <= 3'h0;
      byte_full   <= 1'b0;
      rw          <= 1'b0;
      byte_hi     <= 1'b0;
      rack_nack   <= 1'b0;
      shreg       <= 8'h00;
      cmd         <= 8'h00;
      wlo         <= 8'h00;
      txb         <= 8'h00;
      smb_sda_oe  <= 1'b0;
      smb_sda_out <= 1'b0;
      wr_stb      <= 1'b0;
      wr_cmd      <= 8'h00;
      wr_data     <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        smb_state  <= cor_pkg::SMB_ADDR;
        bit_cnt    <= 3'h0;
        byte_full  <= 1'b0;
        byte_hi    <= 1'b0;
        smb_sda_oe <= 1'b0;
      end else if (stop_c) begin
        smb_state  <= cor_pkg::SMB_IDLE;
        smb_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (smb_state == cor_pkg::SMB_RACK) begin
          rack_nack <= sda_s;
        end else if (smb_state != cor_pkg::SMB_IDLE) begin
          shreg     <= {shreg[6:0], sda_s};
          bit_cnt   <= bit_cnt + 3'h1;
          byte_full <= (bit_cnt == 3'h7);
        end
      end else if (scl_fall) begin
        case (smb_state)
          cor_pkg::SMB_ADDR, cor_pkg::SMB_CMD, cor_pkg::SMB_WDATA: begin
            if (byte_full) begin
              byte_full  <= 1'b0;
              smb_sda_oe <= 1'b1;
              if (smb_state == cor_pkg::SMB_ADDR) begin
                // a foreign address is left alone until the next start
                smb_sda_oe <= (shreg[7:1] == cor_pkg::SLAVE_ADDR);
                smb_state  <= (shreg[7:1] == cor_pkg::SLAVE_ADDR) ? cor_pkg::SMB_AACK : cor_pkg::SMB_IDLE;
                rw         <= shreg[0];
              end else if (smb_state == cor_pkg::SMB_CMD) begin
                cmd       <= shreg;
                smb_state <= cor_pkg::SMB_CACK;
              end else begin
                smb_state <= cor_pkg::SMB_WACK;
                if (!byte_hi) begin
                  wlo     <= shreg;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_cmd  <= cmd;
                  wr_data <= {shreg, wlo};
                end
              end
            end
          end
          cor_pkg::SMB_AACK: begin
            bit_cnt <= 3'h0;
            if (rw) begin
              // the read value is caught once, so both bytes are coherent
              smb_state  <= cor_pkg::SMB_RDATA;
              smb_sda_oe <= ~rd_val[7];
              txb        <= {rd_val[6:0], 1'b0};
              wlo        <= rd_val[15:8];
            end else begin
              smb_state  <= cor_pkg::SMB_CMD;
              smb_sda_oe <= 1'b0;
            end
          end
          cor_pkg::SMB_CACK: begin
            // the ack clock was counted as a bit, restart the count
            bit_cnt    <= 3'h0;
            smb_state  <= cor_pkg::SMB_WDATA;
            smb_sda_oe <= 1'b0;
          end
          cor_pkg::SMB_WACK: begin
            bit_cnt    <= 3'h0;
            smb_sda_oe <= 1'b0;
            smb_state  <= byte_hi ? cor_pkg::SMB_IDLE : cor_pkg::SMB_WDATA;
            byte_hi    <= 1'b1;
          end
          cor_pkg::SMB_RDATA: begin
            if (byte_full) begin
              byte_full  <= 1'b0;
              smb_sda_oe <= 1'b0;
              smb_state  <= cor_pkg::SMB_RACK;
            end else begin
              smb_sda_oe <= ~txb[7];
              txb        <= {txb[6:0], 1'b0};
            end
          end
          cor_pkg::SMB_RACK: begin
            if (!rack_nack && !byte_hi) begin
              smb_state  <= cor_pkg::SMB_RDATA;
              byte_hi    <= 1'b1;
              smb_sda_oe <= ~wlo[7];
              txb        <= {wlo[6:0], 1'b0};
            end else begin
              smb_state <= cor_pkg::SMB_IDLE;
            end
          end
          default: smb_state <= cor_pkg::SMB_IDLE;
        endcase
      end
    end
  end

  assign wr2     = wr_stb && (wr_cmd == cor_pkg::CMD_OPT2);
  assign wr3     = wr_stb && (wr_cmd == cor_pkg::CMD_OPT3);
  assign restore = wr3 && wr_data[cor_pkg::OPT3_REG_RESET_BIT];

  // peak power sequencer
  always_comb begin
    case (charge_option_two.peak_overload_duration) // RULE1
      2'b00:   ovld_ms = cor_pkg::OVLD_MS_0;
      2'b01:   ovld_ms = cor_pkg::OVLD_MS_1;
      2'b10:   ovld_ms = cor_pkg::OVLD_MS_2;
      default: ovld_ms = cor_pkg::OVLD_MS_3;
    endcase
    case (charge_option_two.overload_relax_period) // RULE8
      2'b00:   period_ms = cor_pkg::PERIOD_MS_0;
      2'b01:   period_ms = cor_pkg::PERIOD_MS_1;
      2'b10:   period_ms = cor_pkg::PERIOD_MS_2;
      default: period_ms = cor_pkg::PERIOD_MS_3;
    endcase
  end
  assign relax_ms  = (period_ms > ovld_ms) ? period_ms - ovld_ms : 6'h00; // RULE9
  assign trig      = (charge_option_two.peak_trigger_on_input_overshoot & overshoot_s) | // RULE2
                     (charge_option_two.peak_trigger_on_sys_undershoot & undershoot_s); // RULE3
  assign clr_ovld  = wr2 && charge_option_two.overload_cycle_flag && !wr_data[cor_pkg::OPT2_OVLD_FLAG_BIT];
  assign clr_relax = wr2 && charge_option_two.relax_cycle_flag && !wr_data[cor_pkg::OPT2_RELAX_FLAG_BIT];
  assign tick      = (tick_cnt == 17'(TICK_CYCLES - 1));

  always_comb begin
    next_pk = pk_state;
    case (pk_state)
      cor_pkg::PK_IDLE:
        if (trig) next_pk = cor_pkg::PK_OVLD;
      cor_pkg::PK_OVLD:
        if (clr_ovld) next_pk = cor_pkg::PK_IDLE; // RULE6
        else if (tick && (ms_cnt + 6'h01 >= ovld_ms))
          next_pk = (relax_ms != 6'h00) ? cor_pkg::PK_RELAX : // RULE22
                    (trig ? cor_pkg::PK_OVLD : cor_pkg::PK_IDLE);
      cor_pkg::PK_RELAX:
        if (clr_relax) next_pk = cor_pkg::PK_IDLE; // RULE7
        else if (tick && (ms_cnt + 6'h01 >= relax_ms))
          next_pk = trig ? cor_pkg::PK_OVLD : cor_pkg::PK_IDLE; // RULE22
      default: next_pk = cor_pkg::PK_IDLE;
    endcase
    if (restore || !(charge_option_two.peak_trigger_on_input_overshoot ||
                     charge_option_two.peak_trigger_on_sys_undershoot))
      next_pk = cor_pkg::PK_IDLE; // RULE4
  end

  // interval timing restarts at every phase change so each interval is whole
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pk_state <= cor_pkg::PK_IDLE;
      tick_cnt <= 17'h00000;
      ms_cnt   <= 6'h00;
    end else begin
      pk_state <= next_pk;
      if (next_pk != pk_state || (pk_state == cor_pkg::PK_OVLD && next_pk == cor_pkg::PK_OVLD && tick &&
                                  ms_cnt + 6'h01 >= ovld_ms)) begin
        tick_cnt <= 17'h00000;
        ms_cnt   <= 6'h00;
      end else begin
        tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001;
        if (tick) ms_cnt <= ms_cnt + 6'h01;
      end
    end
  end

  // option registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      charge_option_two   <= cor_pkg::OPT2_RESET; // RULE23 RULE12 RULE13 RULE15 RULE17
      charge_option_three <= cor_pkg::OPT3_RESET; // RULE19
    end else begin
      if (restore) begin
        charge_option_two   <= cor_pkg::OPT2_RESET; // RULE20
        charge_option_three <= cor_pkg::OPT3_RESET; // RULE20
      end else begin
        if (wr2) charge_option_two <= wr_data; // RULE18
        if (wr3) begin
          charge_option_three                   <= wr_data;
          charge_option_three.register_reset    <= 1'b0;
        end else if (measure_done) begin
          charge_option_three.input_voltage_threshold_remeasure <= 1'b0; // RULE21
        end
        if (adapter_q && !adapter_s) begin
          charge_option_two.peak_trigger_on_input_overshoot <= 1'b0; // RULE5
          charge_option_two.peak_trigger_on_sys_undershoot  <= 1'b0; // RULE5
        end
      end
      // status flags are owned by the sequencer, host writes only end a phase
      charge_option_two.overload_cycle_flag <= (next_pk == cor_pkg::PK_OVLD); // RULE6
      charge_option_two.relax_cycle_flag    <= (next_pk == cor_pkg::PK_RELAX); // RULE7
    end
  end

  // protection: faults stay latched until their enable is cleared
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt  <= 14'h0000;
      acoc_trip  <= 1'b0;
      batoc_trip <= 1'b0;
    end else begin
      if (!charge_option_two.input_overcurrent_enable) begin
        acoc_trip <= 1'b0;
        blank_cnt <= 14'h0000;
      end else if (!acoc_s) begin
        blank_cnt <= 14'h0000;
      end else if (blank_cnt == 14'(BLANK_CYCLES - 1)) begin
        acoc_trip <= 1'b1; // RULE14
      end else begin
        blank_cnt <= blank_cnt + 14'h0001;
      end
      if (!charge_option_two.discharge_overcurrent_enable) batoc_trip <= 1'b0;
      else if (batoc_s) batoc_trip <= 1'b1; // RULE16
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      converter_disable           <= 1'b0;
      input_current_limit         <= 8'h00;
      battery_current_monitor_pin <= 8'h00;
      registers_restore           <= 1'b0;
    end else begin
      converter_disable <= acoc_trip | batoc_trip | // RULE14 RULE16
                           charge_option_three.input_voltage_threshold_remeasure; // RULE21
      input_current_limit <= (charge_option_two.external_limit_select &&
                              external_limit_pin < reg_current_limit) ?
                             external_limit_pin : reg_current_limit; // RULE10
      battery_current_monitor_pin <= charge_option_two.current_monitor_direction ?
                                     charge_current : discharge_current; // RULE11
      registers_restore <= restore; // RULE20
    end
  end

  property p_idle_when_disabled;
    @(posedge mclk) disable iff (!rst_n)
      !(charge_option_two.peak_trigger_on_input_overshoot || charge_option_two.peak_trigger_on_sys_undershoot)
      |=> !charge_option_two.overload_cycle_flag && !charge_option_two.relax_cycle_flag;
  endproperty
  a_idle_when_disabled: assert property (p_idle_when_disabled) else $error("flags set with triggers off"); // RULE4

  property p_adapter_clear;
    @(posedge mclk) disable iff (!rst_n)
      (adapter_q && !adapter_s) |=> !charge_option_two.peak_trigger_on_input_overshoot &&
                                    !charge_option_two.peak_trigger_on_sys_undershoot;
  endproperty
  a_adapter_clear: assert property (p_adapter_clear) else $error("triggers kept after adapter removal"); // RULE5

  property p_ovld_exit;
    @(posedge mclk) disable iff (!rst_n)
      clr_ovld |=> !charge_option_two.overload_cycle_flag ##1 !charge_option_two.overload_cycle_flag;
  endproperty
  a_ovld_exit: assert property (p_ovld_exit) else $error("overload not left on host clear"); // RULE6

  property p_no_relax;
    @(posedge mclk) disable iff (!rst_n)
      (pk_state == cor_pkg::PK_OVLD && relax_ms == 6'h00) |=> pk_state != cor_pkg::PK_RELAX;
  endproperty
  a_no_relax: assert property (p_no_relax) else $error("relax entered with no relax time"); // RULE9

  property p_restore;
    @(posedge mclk) disable iff (!rst_n)
      restore |=> charge_option_two == cor_pkg::OPT2_RESET && charge_option_three == cor_pkg::OPT3_RESET
               && registers_restore;
  endproperty
  a_restore: assert property (p_restore) else $error("register reset left non-default values"); // RULE20

  property p_remeasure;
    @(posedge mclk) disable iff (!rst_n)
      charge_option_three.input_voltage_threshold_remeasure |=> converter_disable;
  endproperty
  a_remeasure: assert property (p_remeasure) else $error("converter on during remeasure"); // RULE21

  property p_acoc_blank;
    @(posedge mclk) disable iff (!rst_n)
      $rose(acoc_trip) |-> $past(blank_cnt) == 14'(BLANK_CYCLES - 1) && $past(acoc_s) ##1 converter_disable;
  endproperty
  a_acoc_blank: assert property (p_acoc_blank) else $error("input overcurrent trip without full blanking"); // RULE14

  property p_batoc;
    @(posedge mclk) disable iff (!rst_n)
      (charge_option_two.discharge_overcurrent_enable && batoc_s) |=> ##1 converter_disable;
  endproperty
  a_batoc: assert property (p_batoc) else $error("discharge overcurrent did not disable converter"); // RULE16

  property p_limit;
    @(posedge mclk) disable iff (!rst_n)
      !charge_option_two.external_limit_select |=> input_current_limit == $past(reg_current_limit);
  endproperty
  a_limit: assert property (p_limit) else $error("pin limit used while deselected"); // RULE10

  property p_monitor;
    @(posedge mclk) disable iff (!rst_n)
      charge_option_two.current_monitor_direction |=> battery_current_monitor_pin == $past(charge_current);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor shows wrong current"); // RULE11
endmodule
`default_nettype wire

// ===== hw/cor_sync.sv
`timescale 1ns/10ps
`default_nettype none
module cor_sync #(
  parameter int           W    = 1,
  // reset to the pin's idle level so no false edge follows reset
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verification/cor_smb_host.sv
`timescale 1ns/10ps
`default_nettype none
module cor_smb_host #(
  parameter logic [6:0] ADDR = 7'h09
) (
  // clock
  input  wire logic mclk,
  // bus pins, sda has a pull-up
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp;
    repeat (6) @(posedge mclk);
  endtask
  // sda only moves mid low phase, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda;
    scl <= 1'b0;
    hp;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic na);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, na);
  endtask
  task automatic start;
    sda_low <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b0;
    hp;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, output logic nak);
    logic [7:0] q;
    logic [3:0] n;
    start;
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(cmd, 1'b1, q, n[1]);
    xfer(d[7:0], 1'b1, q, n[2]);
    xfer(d[15:8], 1'b1, q, n[3]);
    stop;
    nak = |n;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic nak);
    logic [7:0] q;
    logic [2:0] n;
    logic       x;
    start;
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(cmd, 1'b1, q, n[1]);
    start;
    xfer({ADDR, 1'b1}, 1'b1, q, n[2]);
    xfer(8'hFF, 1'b0, d[7:0], x);
    xfer(8'hFF, 1'b1, d[15:8], x);
    stop;
    nak = |n;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TICK = 2000;
  logic               mclk, rst_n, adapter_present, input_overshoot, sys_undershoot;
  logic               input_overcurrent, discharge_overcurrent, measure_done, nk;
  logic [7:0]         reg_current_limit, external_limit_pin, charge_current, discharge_current;
  logic [7:0]         input_current_limit, battery_current_monitor_pin;
  logic               scl, sda_low, sda_oe, sda_out, converter_disable, registers_restore;
  logic [15:0]        rv;
  cor_pkg::cor_opt2_s opt2;
  cor_pkg::cor_opt3_s opt3;
  int                 n_errors, n_compared, n_restore;
  wire logic          sda = ~(sda_low | sda_oe);
  cor_regs #(.TICK_CYCLES(TICK), .BLANK_CYCLES(20)) i_cor_regs (.mclk(mclk), .rst_n(rst_n),
    .smb_scl_in(scl), .smb_sda_in(sda), .smb_sda_out(sda_out), .smb_sda_oe(sda_oe),
    .adapter_present(adapter_present), .input_overshoot(input_overshoot), .sys_undershoot(sys_undershoot),
    .input_overcurrent(input_overcurrent), .discharge_overcurrent(discharge_overcurrent),
    .measure_done(measure_done), .reg_current_limit(reg_current_limit), .external_limit_pin(external_limit_pin),
    .charge_current(charge_current), .discharge_current(discharge_current), .charge_option_two(opt2),
    .charge_option_three(opt3), .converter_disable(converter_disable), .input_current_limit(input_current_limit),
    .battery_current_monitor_pin(battery_current_monitor_pin), .registers_restore(registers_restore));
  cor_smb_host i_cor_smb_host (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (registers_restore === 1'b1) n_restore++;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic w(input logic [7:0] c, input logic [15:0] d);
    i_cor_smb_host.wr(c, d, nk);
    chkb(nk, 1'b0);
    cyc(4);
  endtask
  task automatic r(input logic [7:0] c, input logic [15:0] e);
    i_cor_smb_host.rd(c, rv, nk);
    chkb(nk, 1'b0);
    chk(rv, e);
  endtask
  task automatic results;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #480000;
    n_errors++;
    results;
  end
  initial begin
    {rst_n, input_overshoot, sys_undershoot, input_overcurrent, discharge_overcurrent, measure_done} = 6'h00;
    adapter_present = 1'b1;
    {reg_current_limit, external_limit_pin, charge_current, discharge_current} = 32'h4020_1122;
    cyc(4);
    rst_n <= 1'b1;
    cyc(3);
    r(8'h31, 16'h02B7);
    r(8'h32, 16'h0000);
    r(8'h40, 16'h0000);
    chk({8'h00, input_current_limit}, 16'h0020);
    chk({8'h00, battery_current_monitor_pin}, 16'h0022);
    discharge_overcurrent <= 1'b1;
    cyc(5);
    chkb(converter_disable, 1'b1);
    $display("test reset done");
    w(8'h31, 16'hFCFC);
    r(8'h31, 16'hF0FC);
    chkb(converter_disable, 1'b0);
    chk({8'h00, battery_current_monitor_pin}, 16'h0011);
    discharge_overcurrent <= 1'b0;
    adapter_present <= 1'b0;
    cyc(6);
    r(8'h31, 16'hC0FC);
    adapter_present <= 1'b1;
    {input_overshoot, sys_undershoot} <= 2'b11;
    w(8'h31, 16'h0000);
    r(8'h31, 16'h0000);
    chk({8'h00, input_current_limit}, 16'h0040);
    $display("test fields done");
    {input_overshoot, sys_undershoot} <= 2'b00;
    w(8'h31, 16'h0008);
    input_overcurrent <= 1'b1;
    cyc(10);
    input_overcurrent <= 1'b0;
    cyc(30);
    chkb(converter_disable, 1'b0);
    input_overcurrent <= 1'b1;
    cyc(30);
    chkb(converter_disable, 1'b1);
    input_overcurrent <= 1'b0;
    input_overshoot <= 1'b1;
    w(8'h31, 16'h2000);
    chkb(opt2.overload_cycle_flag, 1'b1);
    chkb(converter_disable, 1'b0);
    cyc(TICK);
    chk({opt2.overload_cycle_flag, opt2.relax_cycle_flag}, 16'h0001);
    input_overshoot <= 1'b0;
    w(8'h31, 16'h2000);
    chkb(opt2.relax_cycle_flag, 1'b0);
    sys_undershoot <= 1'b1;
    w(8'h31, 16'h1000);
    chkb(opt2.overload_cycle_flag, 1'b1);
    sys_undershoot <= 1'b0;
    w(8'h31, 16'h1000);
    chkb(opt2.overload_cycle_flag, 1'b0);
    // 10 ms overload against a 5 ms period: no relax may follow
    w(8'h31, 16'h9000);
    sys_undershoot <= 1'b1;
    cyc(4);
    sys_undershoot <= 1'b0;
    cyc(9 * TICK);
    chkb(opt2.overload_cycle_flag, 1'b1);
    cyc(TICK + 10);
    chk({opt2.overload_cycle_flag, opt2.relax_cycle_flag}, 16'h0000);
    $display("test peak power done");
    w(8'h32, 16'h2000);
    chkb(converter_disable, 1'b1);
    r(8'h32, 16'h2000);
    measure_done <= 1'b1;
    cyc(1);
    measure_done <= 1'b0;
    cyc(3);
    chkb(converter_disable, 1'b0);
    chk(opt3, 16'h0000);
    w(8'h31, 16'h0000);
    w(8'h32, 16'h4000);
    r(8'h31, 16'h02B7);
    r(8'h32, 16'h0000);
    chk(16'(n_restore), 16'h0001);
    $display("test option three done");
    results;
  end
endmodule
`default_nettype wire
